// ---- crb_pkg.sv ----
// Package of the CAN receive buffer routing and status block.
// Assumes a 16-bit register port with word indices as addresses.
package crb_pkg;
    // ==========================================================
    // Register indices
    localparam logic [3:0] ADDR_DEST0 = 4'h0;
    localparam logic [3:0] ADDR_DEST1 = 4'h1;
    localparam logic [3:0] ADDR_DEST2 = 4'h2;
    localparam logic [3:0] ADDR_DEST3 = 4'h3;
    localparam logic [3:0] ADDR_FULL_LO = 4'h4;
    localparam logic [3:0] ADDR_FULL_HI = 4'h5;
    localparam logic [3:0] ADDR_OVF_LO = 4'h6;
    localparam logic [3:0] ADDR_OVF_HI = 4'h7;
    localparam logic [3:0] ADDR_FIFO_SETUP = 4'h8;
    localparam logic [3:0] ADDR_FIFO_PTRS = 4'h9;
    localparam logic [3:0] ADDR_FLAGS = 4'ha;
    localparam logic [3:0] ADDR_FLAG_EN = 4'hb;
    localparam logic [3:0] ADDR_FILT_EN = 4'hc;
    // ==========================================================
    // Fields and reset values
    localparam logic [3:0] DEST_FIFO = 4'hf;
    localparam int SIZE_LSB = 13;
    localparam logic [2:0] SIZE_RESERVED = 3'h7;
    localparam logic [15:0] FLAG_W_MASK = 16'h00ef;
    localparam logic [15:0] FILT_EN_RESET = 16'hffff;
    localparam int FLAG_TX = 0;
    localparam int FLAG_RX = 1;
    localparam int FLAG_OVF = 2;
    localparam int FLAG_FIFO = 3;
    localparam int FLAG_ERR = 5;
    localparam int FLAG_WAKE = 6;
    localparam int FLAG_INVALID = 7;
    localparam logic [5:0] FIFO_ALMOST_LEFT = 6'h01;

    // Register port bundle
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } crb_bus_t;

    // Error state bundle from the protocol engine
    typedef struct packed {
        logic tx_bus_off;
        logic tx_error_passive;
        logic rx_error_passive;
        logic tx_error_warning;
        logic rx_error_warning;
    } crb_err_t;

    // Received message hit from acceptance filtering
    typedef struct packed {
        logic valid;
        logic [3:0] filter;
    } crb_hit_t;
endpackage : crb_pkg

// ---- crb_dest_lookup.sv ----
// Destination lookup for one acceptance filter nibble group.
// Assumes destinations are packed four bits per filter.
`timescale 1ns/100ps
module crb_dest_lookup (
    // Configuration
    input wire logic [63:0] dest_all,
    input wire logic [15:0] filt_en,
    // Query
    input wire logic [3:0] filter,
    output logic [3:0] dest,
    output logic enabled
);
    assign dest = dest_all[filter*4 +: 4];
    assign enabled = filt_en[filter];
endmodule : crb_dest_lookup

// ---- crb_flag_bit.sv ----
// One hardware-set, write-zero-to-clear flag bit.
// Assumes set and clear are same-clock pulses.
`timescale 1ns/100ps
module crb_flag_bit (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Control
    input wire logic set,
    input wire logic clr,
    output logic flag_q
);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end
endmodule : crb_flag_bit

// ---- crb_rx_route.sv ----
// CAN receive buffer routing, buffer status, FIFO pointers and event flags.
// Assumes synchronous single-clock event and hit inputs from the protocol engine.
// Behaviour
// - Destination all-ones routes filter hits to FIFO
// - Destination 0..14 routes to that buffer
// - Storing a message sets buffer full bit
// - Storing into full buffer sets overflow bit
// - Write zero clears flags, one keeps them
// - Size field picks buffer count, 111 reserved
// - Start field gives first FIFO buffer
// - Report FIFO next read pointer, five bits
// - Bit 13 shows transmitter bus off
// - Bit 12 shows transmitter error passive
// - Bit 11 shows receiver error passive
// - Bits 10, 9 show tx, rx warning
// - Bit 8 shows either warning state
// - Error flag raised by error state conditions
// - Separate event flags set on their events
// - Unimplemented bits read as zero
// - Disabled filter never routes messages
// - Enables gate requests, never flag setting
`timescale 1ns/100ps
module crb_rx_route (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register port
    input wire crb_pkg::crb_bus_t bus,
    output logic [15:0] rdata,
    // Receive path
    input wire crb_pkg::crb_hit_t hit,
    output logic store_valid,
    output logic [4:0] store_buffer,
    // Engine events
    input wire crb_pkg::crb_err_t err_state,
    input wire logic tx_done,
    input wire logic invalid_message,
    input wire logic wakeup_activity,
    // Interrupt request level
    output logic irq_request
);
    // ==========================================================
    // Configuration registers
    logic [63:0] dest_q;
    logic [15:0] filt_en_q;
    logic [15:0] fifo_setup_q;
    logic [7:0] flag_en_q;

    wire wr_dest = bus.wr && (bus.addr <= crb_pkg::ADDR_DEST3);
    wire wr_setup = bus.wr && (bus.addr == crb_pkg::ADDR_FIFO_SETUP);
    wire wr_flag_en = bus.wr && (bus.addr == crb_pkg::ADDR_FLAG_EN);
    wire wr_filt_en = bus.wr && (bus.addr == crb_pkg::ADDR_FILT_EN);
    wire wr_full_lo = bus.wr && (bus.addr == crb_pkg::ADDR_FULL_LO);
    wire wr_full_hi = bus.wr && (bus.addr == crb_pkg::ADDR_FULL_HI);
    wire wr_ovf_lo = bus.wr && (bus.addr == crb_pkg::ADDR_OVF_LO);
    wire wr_ovf_hi = bus.wr && (bus.addr == crb_pkg::ADDR_OVF_HI);
    wire wr_flags = bus.wr && (bus.addr == crb_pkg::ADDR_FLAGS);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dest_q <= 64'h0;
            filt_en_q <= crb_pkg::FILT_EN_RESET;
            fifo_setup_q <= 16'h0;
            flag_en_q <= 8'h0;
        end else begin
            if (wr_dest) begin
                dest_q[bus.addr[1:0]*16 +: 16] <= bus.wdata;
            end
            if (wr_setup) begin
                fifo_setup_q <= bus.wdata & 16'he01f;
            end
            if (wr_flag_en) begin
                flag_en_q <= bus.wdata[7:0] & crb_pkg::FLAG_W_MASK[7:0];
            end
            if (wr_filt_en) begin
                filt_en_q <= bus.wdata;
            end
        end
    end

    // ==========================================================
    // FIFO geometry
    wire [2:0] ram_buffer_count = fifo_setup_q[crb_pkg::SIZE_LSB +: 3];
    wire [4:0] fifo_start_area = fifo_setup_q[4:0];
    logic [5:0] buf_total;

    always_comb begin
        case (ram_buffer_count)
            3'h0: buf_total = 6'h04;
            3'h1: buf_total = 6'h06;
            3'h2: buf_total = 6'h08;
            3'h3: buf_total = 6'h0c;
            3'h4: buf_total = 6'h10;
            3'h5: buf_total = 6'h18;
            3'h6: buf_total = 6'h20;
            default: buf_total = 6'h20;
        endcase
    end

    wire [4:0] fifo_last = 5'(buf_total - 6'h01);

    // ==========================================================
    // Routing
    logic [3:0] hit_dest;
    logic hit_enabled;

    crb_dest_lookup u_lookup (
        .dest_all(dest_q),
        .filt_en(filt_en_q),
        .filter(hit.filter),
        .dest(hit_dest),
        .enabled(hit_enabled)
    );

    logic [4:0] fifo_current_pointer_q;
    logic [4:0] fifo_next_read_pointer_q;
    logic [31:0] full_q;
    logic [31:0] ovf_q;

    wire accept = hit.valid && hit_enabled;
    wire to_fifo = (hit_dest == crb_pkg::DEST_FIFO);
    wire [4:0] target = to_fifo ? fifo_current_pointer_q : {1'b0, hit_dest};
    wire target_full = full_q[target];
    wire do_store = accept && !target_full;
    wire do_ovf = accept && target_full;

    // ==========================================================
    // Buffer full and overflow bits
    wire [31:0] full_wr = {{16{wr_full_hi}}, {16{wr_full_lo}}};
    wire [31:0] ovf_wr = {{16{wr_ovf_hi}}, {16{wr_ovf_lo}}};
    wire [31:0] wdata2 = {bus.wdata, bus.wdata};
    wire [31:0] full_set = do_store ? (32'h1 << target) : 32'h0;
    wire [31:0] ovf_set = do_ovf ? (32'h1 << target) : 32'h0;
    wire [31:0] full_clr = full_wr & ~wdata2;
    wire [31:0] ovf_clr = ovf_wr & ~wdata2;

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_buf
            crb_flag_bit u_full (
                .sys_clk(sys_clk),
                .resetn(resetn),
                .set(full_set[gi]),
                .clr(full_clr[gi]),
                .flag_q(full_q[gi])
            );
            crb_flag_bit u_ovf (
                .sys_clk(sys_clk),
                .resetn(resetn),
                .set(ovf_set[gi]),
                .clr(ovf_clr[gi]),
                .flag_q(ovf_q[gi])
            );
        end
    endgenerate

    // ==========================================================
    // FIFO pointers
    wire setup_change = wr_setup;
    wire fifo_store = do_store && to_fifo;
    // A clear that loses to a same-cycle store leaves the buffer full: no advance
    wire read_done = full_clr[fifo_next_read_pointer_q]
        && full_q[fifo_next_read_pointer_q]
        && !full_set[fifo_next_read_pointer_q];
    wire [5:0] fifo_len = 6'(buf_total - {1'b0, fifo_start_area});
    logic [5:0] fifo_used_q;

    // Pointer steps wrap from the last buffer back to the start area
    wire [4:0] write_step = (fifo_current_pointer_q >= fifo_last) ? fifo_start_area
        : 5'(fifo_current_pointer_q + 5'h01);
    wire [4:0] read_step = (fifo_next_read_pointer_q >= fifo_last) ? fifo_start_area
        : 5'(fifo_next_read_pointer_q + 5'h01);
    wire [4:0] fifo_current_pointer_d = setup_change ? bus.wdata[4:0]
        : (fifo_store ? write_step : fifo_current_pointer_q);
    wire [4:0] fifo_next_read_pointer_d = setup_change ? bus.wdata[4:0]
        : (read_done ? read_step : fifo_next_read_pointer_q);
    wire fifo_inc = fifo_store && !read_done;
    wire fifo_dec = read_done && !fifo_store && (fifo_used_q != 6'h00);
    wire [5:0] fifo_used_d = setup_change ? 6'h00
        : (fifo_inc ? 6'(fifo_used_q + 6'h01)
        : (fifo_dec ? 6'(fifo_used_q - 6'h01) : fifo_used_q));

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fifo_current_pointer_q <= 5'h0;
            fifo_next_read_pointer_q <= 5'h0;
            fifo_used_q <= 6'h0;
        end else begin
            fifo_current_pointer_q <= fifo_current_pointer_d;
            fifo_next_read_pointer_q <= fifo_next_read_pointer_d;
            fifo_used_q <= fifo_used_d;
        end
    end

    wire fifo_almost = fifo_store
        && (6'(fifo_used_q + 6'h01) >= 6'(fifo_len - crb_pkg::FIFO_ALMOST_LEFT));

    // ==========================================================
    // Error state and event flags
    crb_pkg::crb_err_t err_s1_q;
    crb_pkg::crb_err_t err_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            err_s1_q <= '0;
            err_q <= '0;
        end else begin
            err_s1_q <= err_state;
            err_q <= err_s1_q;
        end
    end

    wire any_error_warning = err_q.tx_error_warning | err_q.rx_error_warning;
    wire [5:0] err_bits = {err_q.tx_bus_off, err_q.tx_error_passive,
        err_q.rx_error_passive, err_q.tx_error_warning,
        err_q.rx_error_warning, any_error_warning};
    crb_pkg::crb_err_t err_prev_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            err_prev_q <= '0;
        end else begin
            err_prev_q <= err_q;
        end
    end

    wire err_event = |(err_q & ~err_prev_q);
    logic [7:0] flags_q;
    wire [7:0] flag_set = {invalid_message, wakeup_activity, err_event, 1'b0,
        fifo_almost, do_ovf, do_store, tx_done};
    wire [7:0] flag_clr = {8{wr_flags}} & ~bus.wdata[7:0];

    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            if (crb_pkg::FLAG_W_MASK[gi]) begin : g_impl
                crb_flag_bit u_flag (
                    .sys_clk(sys_clk),
                    .resetn(resetn),
                    .set(flag_set[gi]),
                    .clr(flag_clr[gi]),
                    .flag_q(flags_q[gi])
                );
            end else begin : g_none
                assign flags_q[gi] = 1'b0;
            end
        end
    endgenerate

    assign irq_request = |(flags_q & flag_en_q);

    // ==========================================================
    // Outputs and read port
    logic [15:0] rdata_d;

    always_comb begin
        case (bus.addr)
            crb_pkg::ADDR_DEST0: rdata_d = dest_q[15:0];
            crb_pkg::ADDR_DEST1: rdata_d = dest_q[31:16];
            crb_pkg::ADDR_DEST2: rdata_d = dest_q[47:32];
            crb_pkg::ADDR_DEST3: rdata_d = dest_q[63:48];
            crb_pkg::ADDR_FULL_LO: rdata_d = full_q[15:0];
            crb_pkg::ADDR_FULL_HI: rdata_d = full_q[31:16];
            crb_pkg::ADDR_OVF_LO: rdata_d = ovf_q[15:0];
            crb_pkg::ADDR_OVF_HI: rdata_d = ovf_q[31:16];
            crb_pkg::ADDR_FIFO_SETUP: rdata_d = fifo_setup_q;
            crb_pkg::ADDR_FIFO_PTRS: rdata_d = {3'h0, fifo_current_pointer_q,
                3'h0, fifo_next_read_pointer_q};
            crb_pkg::ADDR_FLAGS: rdata_d = {2'h0, err_bits, flags_q};
            crb_pkg::ADDR_FLAG_EN: rdata_d = {8'h0, flag_en_q};
            crb_pkg::ADDR_FILT_EN: rdata_d = filt_en_q;
            default: rdata_d = 16'h0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 16'h0;
            store_valid <= 1'b0;
            store_buffer <= 5'h0;
        end else begin
            rdata <= bus.rd ? rdata_d : 16'h0;
            store_valid <= do_store;
            store_buffer <= target;
        end
    end
endmodule : crb_rx_route

// ---- crb_rx_route_monitor.sv ----
// Port checker for the receive routing block.
// Assumes one clock domain; bound to every crb_rx_route instance.
`timescale 1ns/100ps
module crb_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Observed ports
    input wire crb_pkg::crb_bus_t bus,
    input wire logic [15:0] rdata,
    input wire crb_pkg::crb_hit_t hit,
    input wire logic store_valid,
    input wire logic [4:0] store_buffer,
    input wire crb_pkg::crb_err_t err_state
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [4:0] stored_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) stored_q <= 5'h00;
        else if (store_valid) stored_q <= store_buffer;
    end
    // =========
    // Properties
    sequence s_rd(a); bus.rd && bus.addr == a; endsequence
    sequence s_stored; store_valid && !bus.wr; endsequence
    property p_rd_idle; !$past(bus.rd) |-> rdata == 16'h0000; endproperty
    property p_store_cause; store_valid |-> $past(hit.valid); endproperty
    property p_ptrs; s_rd(crb_pkg::ADDR_FIFO_PTRS) |=> (rdata & 16'he0e0) == 16'h0000; endproperty
    property p_setup; s_rd(crb_pkg::ADDR_FIFO_SETUP) |=> rdata[12:5] == 8'h00; endproperty
    property p_flag_pad;
        s_rd(crb_pkg::ADDR_FLAGS) |=> rdata[15:14] == 2'h0 && rdata[4] == 1'b0;
    endproperty
    property p_err;
        $stable(err_state)[*5] ##0 s_rd(crb_pkg::ADDR_FLAGS) |=> rdata[13:8] ==
            {$past(err_state), $past(err_state.tx_error_warning) | $past(err_state.rx_error_warning)};
    endproperty
    property p_rx_flag; s_stored ##1 s_rd(crb_pkg::ADDR_FLAGS) |=> rdata[1]; endproperty
    property p_full;
        s_stored ##1 (!store_valid && bus.rd && bus.addr == {3'h2, stored_q[4]})
            |=> rdata[stored_q[3:0]];
    endproperty
    property p_wc_keep;
        s_rd(crb_pkg::ADDR_FLAGS) ##1 (bus.wr && bus.addr == crb_pkg::ADDR_FLAGS
            && bus.wdata == 16'hffff) ##1 s_rd(crb_pkg::ADDR_FLAGS) |=>
            (rdata & $past(rdata, 2) & 16'h00ef) == ($past(rdata, 2) & 16'h00ef);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    a_store_cause: assert property (p_store_cause) else $error("store without hit");
    a_ptrs: assert property (p_ptrs) else $error("pointer field out of range");
    a_setup: assert property (p_setup) else $error("setup pad bits set");
    a_flag_pad: assert property (p_flag_pad) else $error("flag pad bits set");
    a_err: assert property (p_err) else $error("error status mismatch");
    a_rx_flag: assert property (p_rx_flag) else $error("receive flag not set");
    a_full: assert property (p_full) else $error("full bit not set");
    a_wc_keep: assert property (p_wc_keep) else $error("write one changed flag");
endmodule : crb_monitor

bind crb_rx_route crb_monitor u_mon (.sys_clk(sys_clk), .resetn(resetn), .bus(bus),
    .rdata(rdata), .hit(hit), .store_valid(store_valid), .store_buffer(store_buffer),
    .err_state(err_state));

// ---- crb_peer.sv ----
// Model of the protocol engine side: filter hits, events, error state.
// Assumes the testbench calls its tasks one at a time.
`timescale 1ns/100ps
module crb_peer (
    // Clock
    input wire logic sys_clk,
    // Engine outputs
    output crb_pkg::crb_hit_t hit,
    output crb_pkg::crb_err_t err_state,
    output logic tx_done,
    output logic invalid_message,
    output logic wakeup_activity
);
    initial begin
        hit = '0;
        err_state = '0;
        {tx_done, invalid_message, wakeup_activity} = 3'h0;
    end
    // Filter index is scrambled while no hit is offered
    task send_hit(input logic [3:0] f);
        @(posedge sys_clk);
        hit <= '{1'b1, f};
        @(posedge sys_clk);
        hit <= '{1'b0, ~f};
    endtask : send_hit
    task pulse(input logic [2:0] ev);
        @(posedge sys_clk);
        {tx_done, invalid_message, wakeup_activity} <= ev;
        @(posedge sys_clk);
        {tx_done, invalid_message, wakeup_activity} <= 3'h0;
    endtask : pulse
    task set_err(input crb_pkg::crb_err_t e);
        @(posedge sys_clk);
        err_state <= e;
    endtask : set_err
endmodule : crb_peer

// ---- crb_tb.sv ----
// Self-checking testbench of the receive routing block.
// Assumes the peer model drives the engine side.
`timescale 1ns/100ps
module tb;
    logic sys_clk;
    logic resetn;
    crb_pkg::crb_bus_t bus;
    logic [15:0] rdata;
    crb_pkg::crb_hit_t hit;
    crb_pkg::crb_err_t err_state;
    logic store_valid, tx_done, invalid_message, wakeup_activity, irq_request;
    logic [4:0] store_buffer;
    int fail_count = 0;
    int n_compared = 0;
    crb_rx_route uut (.sys_clk(sys_clk), .resetn(resetn), .bus(bus), .rdata(rdata), .hit(hit),
        .store_valid(store_valid), .store_buffer(store_buffer), .err_state(err_state),
        .tx_done(tx_done), .invalid_message(invalid_message),
        .wakeup_activity(wakeup_activity), .irq_request(irq_request));
    crb_peer peer (.sys_clk(sys_clk), .hit(hit), .err_state(err_state), .tx_done(tx_done),
        .invalid_message(invalid_message), .wakeup_activity(wakeup_activity));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // =========
    // Bus and check tasks
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task op(input logic [3:0] a, input logic [15:0] d, input logic w);
        @(posedge sys_clk);
        bus <= '{a, d, w, !w};
    endtask : op
    task wr(input logic [3:0] a, input logic [15:0] d);
        op(a, d, 1'b1);
        @(posedge sys_clk);
        bus <= '0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [15:0] exp);
        op(a, 16'h0000, 1'b0);
        @(posedge sys_clk);
        bus <= '0;
        #1 chk(rdata, exp);
    endtask : rd
    task hit_chk(input logic [3:0] f, input logic v, input logic [4:0] b);
        peer.send_hit(f);
        #1 chk({10'h000, store_valid, v ? store_buffer : 5'h00}, {10'h000, v, b});
    endtask : hit_chk
    task complete_run;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    // =========
    // Scenarios
    task t_reset;
        for (int i = 0; i < 14; i++) rd(i[3:0], (i == 12) ? 16'hffff : 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_fifo;
        int cnt [8] = '{4, 6, 8, 12, 16, 24, 32, 32};
        wr(4'h3, 16'hf000);
        for (int s = 0; s < 8; s++) begin
            wr(4'h4, 16'h0000);
            wr(4'h5, 16'h0000);
            wr(4'ha, 16'h0000);
            wr(4'h8, {s[2:0], 8'h00, 5'(cnt[s] - 2)});
            hit_chk(4'hf, 1'b1, 5'(cnt[s] - 2));
            rd(4'ha, 16'h000a);
            hit_chk(4'hf, 1'b1, 5'(cnt[s] - 1));
            rd(4'h9, {2'h0, 6'(cnt[s] - 2), 2'h0, 6'(cnt[s] - 2)});
        end
        rd(4'h8, 16'he01e);
        wr(4'h5, 16'hbfff);
        wr(4'h9, 16'hffff);
        rd(4'h9, 16'h1e1f);
        hit_chk(4'hf, 1'b1, 5'h1e);
        rd(4'h5, 16'hc000);
        hit_chk(4'hf, 1'b0, 5'h00);
        rd(4'h7, 16'h8000);
        $display("test fifo done");
    endtask : t_fifo
    task t_route;
        wr(4'h4, 16'h0000);
        wr(4'ha, 16'h0000);
        wr(4'h0, 16'h3210);
        wr(4'h1, 16'h7654);
        wr(4'h2, 16'hba98);
        wr(4'h3, 16'hfedc);
        for (int f = 0; f < 15; f++) hit_chk(f[3:0], 1'b1, {1'b0, f[3:0]});
        rd(4'h4, 16'h7fff);
        hit_chk(4'h3, 1'b0, 5'h00);
        rd(4'h6, 16'h0008);
        rd(4'ha, 16'h0006);
        wr(4'hc, 16'hfffe);
        hit_chk(4'h0, 1'b0, 5'h00);
        rd(4'h6, 16'h0008);
        wr(4'hc, 16'hffff);
        $display("test route done");
    endtask : t_route
    task t_flags;
        wr(4'ha, 16'h0000);
        peer.pulse(3'h7);
        rd(4'ha, 16'h00c1);
        chk({15'h0000, irq_request}, 16'h0000);
        wr(4'hb, 16'h0001);
        #1 chk({15'h0000, irq_request}, 16'h0001);
        op(4'ha, 16'h0000, 1'b0);
        op(4'ha, 16'hffff, 1'b1);
        rd(4'ha, 16'h00c1);
        wr(4'ha, 16'h00fe);
        #1 chk({15'h0000, irq_request}, 16'h0000);
        rd(4'ha, 16'h00c0);
        $display("test flags done");
    endtask : t_flags
    task t_err;
        for (int i = 0; i < 5; i++) begin
            wr(4'ha, 16'h0000);
            peer.set_err(5'(1 << i));
            repeat (5) @(posedge sys_clk);
            rd(4'ha, {2'h0, 5'(1 << i), 1'(i < 2), 8'h20});
        end
        peer.set_err(5'h00);
        $display("test error done");
    endtask : t_err
    initial begin
        bus = '0;
        resetn = 1'b0;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_fifo();
        t_route();
        t_flags();
        t_err();
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        complete_run();
    end
endmodule : tb
